// ---- rtl/nbc_pkg.sv ----
/*
  shared constants and types for the non-pipelined bus cycle sequencer:
  widths, cycle definition codes, special addresses, operand sizes, states.
  assumes nothing of its surroundings; compiled before every design file.
*/
package nbc_pkg;
  localparam int DATA_W = 16; // data lines width
  localparam int ADDR_W = 24; // byte address width
  localparam int WADDR_W = 23; // word address lines width
  localparam int OPER_W = 32; // widest operand
  localparam int BYTE_W = 8; // one byte lane
  localparam int CNT_W = 3; // byte counts up to four

  // phase of the double-rate clock inside one bus state
  localparam logic PH_ONE = 1'b0;
  localparam logic PH_TWO = 1'b1;

  // cycle definition codes as {memory/io, data/control, write/read}
  localparam logic [2:0] DEF_INTA = 3'h0;
  localparam logic [2:0] DEF_IO_RD = 3'h2;
  localparam logic [2:0] DEF_IO_WR = 3'h3;
  localparam logic [2:0] DEF_CODE_RD = 3'h4;
  localparam logic [2:0] DEF_HALT = 3'h5;
  localparam logic [2:0] DEF_MEM_RD = 3'h6;
  localparam logic [2:0] DEF_MEM_WR = 3'h7;

  // fixed word addresses of the halt and shutdown cycles
  localparam logic [WADDR_W-1:0] HALT_WADDR = 23'h000002;
  localparam logic [WADDR_W-1:0] SHUT_WADDR = 23'h000000;

  // operand byte counts and per-cycle byte takes
  localparam logic [CNT_W-1:0] BYTES_8 = 3'h1;
  localparam logic [CNT_W-1:0] BYTES_16 = 3'h2;
  localparam logic [CNT_W-1:0] BYTES_32 = 3'h4;
  localparam logic [1:0] TAKE_ONE = 2'h1;
  localparam logic [1:0] TAKE_TWO = 2'h2;

  // kinds of cycle the core may ask for
  typedef enum logic [2:0] {
    NBC_MEM_RD, NBC_MEM_WR, NBC_IO_RD, NBC_IO_WR,
    NBC_CODE_RD, NBC_INTA, NBC_HALT, NBC_SHUTDOWN
  } nbc_kind_t;

  // operand sizes
  typedef enum logic [1:0] {NBC_SZ8, NBC_SZ16, NBC_SZ32} nbc_size_t;

  // bus states: first, second (and wait), idle, hold acknowledge
  typedef enum logic [1:0] {NBC_IDLE, NBC_FIRST, NBC_SECOND, NBC_HOLD_ACK} nbc_state_t;
endpackage

// ---- rtl/nbc_piece.sv ----
/*
  splits an operand into one bus cycle worth of bytes: picks the byte
  lanes and how many bytes the next cycle moves.
  assumes the caller holds the current byte address and bytes left.
*/
`timescale 1ns/1ps
module nbc_piece (
  input wire logic addr_lsb,
  input wire logic [nbc_pkg::CNT_W-1:0] remaining,
  output logic low_en,
  output logic high_en,
  output logic [1:0] take
);
  import nbc_pkg::*;

  // odd address only reaches the high lane; even may take a whole word
  always_comb begin
    if (addr_lsb) begin
      low_en = 1'b0;
      high_en = 1'b1;
      take = TAKE_ONE;
    end else if (remaining >= BYTES_16) begin
      low_en = 1'b1;
      high_en = 1'b1;
      take = TAKE_TWO;
    end else begin
      low_en = 1'b1;
      high_en = 1'b0;
      take = TAKE_ONE;
    end
  end
endmodule

// ---- rtl/nbc_bus_seq.sv ----
/*
  non-pipelined bus cycle sequencer on the double-rate clock: takes
  operands from the core, runs first/second/idle/hold bus states on the
  pins and returns read data.
  assumes pins are joined to tri-state pads by the enables given here and
  that the core holds a request steady until req_ready.
*/
`timescale 1ns/1ps
module nbc_bus_seq (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire nbc_pkg::nbc_kind_t req_kind,
  input wire nbc_pkg::nbc_size_t req_size,
  input wire logic req_lock,
  input wire logic [nbc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [nbc_pkg::OPER_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [nbc_pkg::OPER_W-1:0] rsp_rdata,
  output logic address_strobe_n,
  output logic [nbc_pkg::WADDR_W-1:0] word_address_lines,
  output logic high_byte_enable_n,
  output logic low_byte_enable_n,
  output logic mem_io_sel,
  output logic data_ctrl_sel,
  output logic write_read_sel,
  output logic lock_n,
  output logic cycle_def_oe_n,
  input wire logic [nbc_pkg::DATA_W-1:0] data_lines_in,
  output logic [nbc_pkg::DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_n,
  input wire logic ready_n,
  input wire logic next_address_request_n,
  input wire logic hold_request,
  output logic bus_grant_acknowledge,
  output logic pipeline_handoff
);
  import nbc_pkg::*;

  // cycle definition code of a request kind
  function automatic logic [2:0] def_code(input nbc_kind_t k);
    case (k)
      NBC_MEM_RD: def_code = DEF_MEM_RD;
      NBC_MEM_WR: def_code = DEF_MEM_WR;
      NBC_IO_RD: def_code = DEF_IO_RD;
      NBC_IO_WR: def_code = DEF_IO_WR;
      NBC_CODE_RD: def_code = DEF_CODE_RD;
      NBC_INTA: def_code = DEF_INTA;
      default: def_code = DEF_HALT;
    endcase
  endfunction

  // bit offset of a byte count
  function automatic logic [5:0] byte_pos(input logic [CNT_W-1:0] n);
    byte_pos = {n, 3'h0};
  endfunction

  // pin synchronisers; first stage read only by the second
  logic rdy_s1_q, rdy_s2_q; // ready, active low
  logic nx_s1_q, nx_s2_q; // next-address, active low
  logic hold_s1_q, hold_s2_q; // hold request
  logic [DATA_W-1:0] din_s1_q, din_s2_q; // read data, same latency as ready

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdy_s1_q <= 1'b1;
      rdy_s2_q <= 1'b1;
      nx_s1_q <= 1'b1;
      nx_s2_q <= 1'b1;
      hold_s1_q <= 1'b0;
      hold_s2_q <= 1'b0;
      din_s1_q <= 16'h0000;
      din_s2_q <= 16'h0000;
    end else begin
      rdy_s1_q <= ready_n;
      rdy_s2_q <= rdy_s1_q;
      nx_s1_q <= next_address_request_n;
      nx_s2_q <= nx_s1_q;
      hold_s1_q <= hold_request;
      hold_s2_q <= hold_s1_q;
      din_s1_q <= data_lines_in;
      din_s2_q <= din_s1_q;
    end
  end

  logic rdy_act, nx_act;
  assign rdy_act = ~rdy_s2_q;
  assign nx_act = ~nx_s2_q;

  // sequencer state
  nbc_state_t state_q, state_d;
  logic phase_q, phase_d; // which half of the bus state
  logic wait_q, wait_d; // current second state is a wait state
  logic stb_n_q, stb_n_d;
  logic [WADDR_W-1:0] waddr_q, waddr_d;
  logic hen_n_q, hen_n_d, len_n_q, len_n_d;
  logic [2:0] def_q, def_d; // {memory/io, data/control, write/read}
  logic lock_n_q, lock_n_d;
  logic def_oe_n_q, def_oe_n_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic dout_oe_n_q, dout_oe_n_d;
  logic wr_hold_q, wr_hold_d; // write data still in hold phase
  logic grant_q, grant_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [OPER_W-1:0] rsp_rdata_q, rsp_rdata_d;
  logic pipe_q, pipe_d;
  // operand being moved
  logic [ADDR_W-1:0] op_addr_q, op_addr_d;
  logic [CNT_W-1:0] op_rem_q, op_rem_d; // bytes not yet moved
  logic [CNT_W-1:0] op_done_q, op_done_d; // bytes already moved
  logic [OPER_W-1:0] wbuf_q, wbuf_d; // unsent write bytes, low first
  logic [OPER_W-1:0] rbuf_q, rbuf_d; // gathered read bytes
  logic [1:0] take_q, take_d; // bytes in the current cycle

  // next-piece source: continue current operand or take a new one
  logic [ADDR_W-1:0] nxt_addr, src_addr;
  logic [CNT_W-1:0] nxt_rem, src_rem, new_rem;
  logic use_cont, go_new, go_cont, is_wr, ack;
  logic pc_low, pc_high;
  logic [1:0] pc_take;
  logic [DATA_W-1:0] rd_bytes;
  logic [OPER_W-1:0] rd_merge;

  assign nxt_addr = op_addr_q + ADDR_W'(take_q);
  assign nxt_rem = op_rem_q - CNT_W'(take_q);
  assign use_cont = (state_q == NBC_SECOND) && (nxt_rem != '0);
  assign is_wr = def_q[0];

  // special cycles move one byte; halt and shutdown at a fixed word address
  always_comb begin
    new_rem = (req_size == NBC_SZ8) ? BYTES_8 : ((req_size == NBC_SZ16) ? BYTES_16 : BYTES_32);
    src_addr = req_addr;
    if (req_kind == NBC_HALT) begin
      src_addr = {HALT_WADDR, 1'b0};
      new_rem = BYTES_8;
    end else if (req_kind == NBC_SHUTDOWN) begin
      src_addr = {SHUT_WADDR, 1'b0};
      new_rem = BYTES_8;
    end else if (req_kind == NBC_INTA) begin
      new_rem = BYTES_8;
    end
    src_rem = new_rem;
    if (use_cont) begin
      src_addr = nxt_addr;
      src_rem = nxt_rem;
    end
  end

  nbc_piece u_piece (
    .addr_lsb(src_addr[0]),
    .remaining(src_rem),
    .low_en(pc_low),
    .high_en(pc_high),
    .take(pc_take)
  );

  // read bytes of this cycle, placed at the gathered position
  always_comb begin
    if (op_addr_q[0]) begin
      rd_bytes = {8'h00, din_s2_q[15:8]};
    end else if (take_q == TAKE_TWO) begin
      rd_bytes = din_s2_q;
    end else begin
      rd_bytes = {8'h00, din_s2_q[7:0]};
    end
    rd_merge = rbuf_q | ({16'h0000, rd_bytes} << byte_pos(op_done_q));
  end

  // next values of the whole sequencer; states change at phase-two ends
  always_comb begin
    state_d = state_q;
    phase_d = ~phase_q;
    wait_d = wait_q;
    stb_n_d = stb_n_q;
    waddr_d = waddr_q;
    hen_n_d = hen_n_q;
    len_n_d = len_n_q;
    def_d = def_q;
    lock_n_d = lock_n_q;
    def_oe_n_d = def_oe_n_q;
    dout_d = dout_q;
    dout_oe_n_d = dout_oe_n_q;
    wr_hold_d = 1'b0;
    grant_d = grant_q;
    rsp_valid_d = 1'b0;
    rsp_rdata_d = rsp_rdata_q;
    pipe_d = 1'b0;
    op_addr_d = op_addr_q;
    op_rem_d = op_rem_q;
    op_done_d = op_done_q;
    wbuf_d = wbuf_q;
    rbuf_d = rbuf_q;
    take_d = take_q;
    go_new = 1'b0;
    go_cont = 1'b0;
    ack = 1'b0;
    // write data released after its hold phase
    if (wr_hold_q) begin
      dout_oe_n_d = 1'b1;
    end
    case (state_q)
      NBC_IDLE: begin
        // no definition output changes here; only strobe stays off
        if (phase_q == PH_TWO) begin
          if (hold_s2_q) begin
            state_d = NBC_HOLD_ACK;
          end else if (req_valid) begin
            go_new = 1'b1;
          end
        end
      end
      NBC_FIRST: begin
        if (phase_q == PH_ONE && is_wr) begin
          // lanes: odd address puts its byte on the high lane
          dout_d = op_addr_q[0] ? {wbuf_q[7:0], 8'h00} : wbuf_q[15:0];
          dout_oe_n_d = 1'b0;
        end
        if (phase_q == PH_TWO) begin
          // ready is not looked at here
          state_d = NBC_SECOND;
          stb_n_d = 1'b1;
          wait_d = 1'b0;
        end
      end
      NBC_SECOND: begin
        if (phase_q == PH_ONE && wait_q && nx_act) begin
          pipe_d = 1'b1;
        end
        if (phase_q == PH_TWO) begin
          if (rdy_act) begin
            ack = 1'b1;
            op_addr_d = nxt_addr;
            op_rem_d = nxt_rem;
            op_done_d = op_done_q + CNT_W'(take_q);
            wbuf_d = wbuf_q >> byte_pos(CNT_W'(take_q));
            if (is_wr) begin
              wr_hold_d = 1'b1;
            end else begin
              rbuf_d = rd_merge;
            end
            if (nxt_rem != '0) begin
              go_cont = 1'b1;
            end else begin
              rsp_valid_d = 1'b1;
              rsp_rdata_d = is_wr ? rbuf_q : rd_merge;
              if (hold_s2_q) begin
                state_d = NBC_HOLD_ACK;
              end else if (req_valid) begin
                go_new = 1'b1;
              end else begin
                state_d = NBC_IDLE;
              end
            end
          end else begin
            wait_d = 1'b1;
          end
        end
      end
      NBC_HOLD_ACK: begin
        if (phase_q == PH_TWO && !hold_s2_q) begin
          state_d = NBC_IDLE;
        end
      end
      default: state_d = NBC_IDLE;
    endcase
    // hold: float definition only, address stays driven, raise grant
    if (state_d == NBC_HOLD_ACK && state_q != NBC_HOLD_ACK) begin
      def_oe_n_d = 1'b1;
      grant_d = 1'b1;
    end else if (state_d != NBC_HOLD_ACK) begin
      def_oe_n_d = 1'b0;
      grant_d = 1'b0;
    end
    // new operand latched at its first cycle
    if (go_new) begin
      op_addr_d = src_addr;
      op_rem_d = src_rem;
      op_done_d = '0;
      wbuf_d = req_wdata;
      rbuf_d = '0;
      def_d = def_code(req_kind);
      lock_n_d = ~(req_lock | (req_kind == NBC_INTA));
    end
    // every cycle: address, enables, definition and strobe together
    if (go_new || go_cont) begin
      state_d = NBC_FIRST;
      stb_n_d = 1'b0;
      waddr_d = src_addr[ADDR_W-1:1];
      hen_n_d = ~pc_high;
      len_n_d = ~pc_low;
      take_d = pc_take;
    end
  end

  // registers of the sequencer; reset aborts any cycle or hold
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= NBC_IDLE;
      phase_q <= PH_ONE;
      wait_q <= 1'b0;
      stb_n_q <= 1'b1;
      waddr_q <= '0;
      hen_n_q <= 1'b1;
      len_n_q <= 1'b1;
      def_q <= DEF_INTA;
      lock_n_q <= 1'b1;
      def_oe_n_q <= 1'b0;
      dout_q <= 16'h0000;
      dout_oe_n_q <= 1'b1;
      wr_hold_q <= 1'b0;
      grant_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= '0;
      pipe_q <= 1'b0;
      op_addr_q <= '0;
      op_rem_q <= '0;
      op_done_q <= '0;
      wbuf_q <= '0;
      rbuf_q <= '0;
      take_q <= TAKE_ONE;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      wait_q <= wait_d;
      stb_n_q <= stb_n_d;
      waddr_q <= waddr_d;
      hen_n_q <= hen_n_d;
      len_n_q <= len_n_d;
      def_q <= def_d;
      lock_n_q <= lock_n_d;
      def_oe_n_q <= def_oe_n_d;
      dout_q <= dout_d;
      dout_oe_n_q <= dout_oe_n_d;
      wr_hold_q <= wr_hold_d;
      grant_q <= grant_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_rdata_q <= rsp_rdata_d;
      pipe_q <= pipe_d;
      op_addr_q <= op_addr_d;
      op_rem_q <= op_rem_d;
      op_done_q <= op_done_d;
      wbuf_q <= wbuf_d;
      rbuf_q <= rbuf_d;
      take_q <= take_d;
    end
  end

  // outputs straight from flops; handshake ready is combinational
  assign req_ready = go_new;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign address_strobe_n = stb_n_q;
  assign word_address_lines = waddr_q;
  assign high_byte_enable_n = hen_n_q;
  assign low_byte_enable_n = len_n_q;
  assign {mem_io_sel, data_ctrl_sel, write_read_sel} = def_q;
  assign lock_n = lock_n_q;
  assign cycle_def_oe_n = def_oe_n_q;
  assign data_lines_out = dout_q;
  assign data_lines_oe_n = dout_oe_n_q;
  assign bus_grant_acknowledge = grant_q;
  assign pipeline_handoff = pipe_q;

  a_strobe_len: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(address_strobe_n) |-> !address_strobe_n ##2 address_strobe_n)
    else $error("strobe not one bus state long");
  a_first_then_second: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == NBC_FIRST && phase_q == PH_TWO) |=> state_q == NBC_SECOND)
    else $error("first state not followed by second");
  a_wait_repeats: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == NBC_SECOND && phase_q == PH_TWO && !rdy_act) |=> state_q == NBC_SECOND)
    else $error("second state not repeated without ready");
  a_addr_stable_wait: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == NBC_SECOND && $past(state_q) == NBC_SECOND)
    |-> $stable(word_address_lines) && $stable(def_q) && $stable(lock_n))
    else $error("address changed in wait state");
  a_write_drive: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == NBC_FIRST && phase_q == PH_ONE && write_read_sel) |=> !data_lines_oe_n)
    else $error("write data not driven in phase two");
  a_read_float: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == NBC_SECOND && !write_read_sel && $past(state_q) == NBC_SECOND)
    |-> data_lines_oe_n)
    else $error("data driven during read");
  a_hold_float: assert property (@(posedge clk) disable iff (sys_rst)
    bus_grant_acknowledge |-> cycle_def_oe_n && state_q == NBC_HOLD_ACK)
    else $error("definition driven during hold");
  a_inta_locked: assert property (@(posedge clk) disable iff (sys_rst)
    (!address_strobe_n && {mem_io_sel, data_ctrl_sel, write_read_sel} == DEF_INTA)
    |-> !lock_n)
    else $error("acknowledge cycle not locked");
  a_state_even: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q != $past(state_q)) |-> phase_q == PH_ONE)
    else $error("state changed mid bus state");
  a_resp_after_ack: assert property (@(posedge clk) disable iff (sys_rst)
    rsp_valid |-> $past(state_q) == NBC_SECOND && $past(rdy_act))
    else $error("response without acknowledge");
endmodule

// ---- sim/nbc_partner.sv ----
/*
  memory and io controller model on the sequencer pins.
  assumes pins move on rising clk; answers on falling clk as the bench sets.
*/
`timescale 1ns/1ps
module nbc_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic address_strobe_n,
  input wire logic [nbc_pkg::WADDR_W-1:0] word_address_lines,
  input wire logic high_byte_enable_n,
  input wire logic low_byte_enable_n,
  input wire logic write_read_sel,
  input wire logic [nbc_pkg::DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe_n,
  input wire logic [3:0] wait_states,
  input wire logic nx_in_wait,
  output logic [nbc_pkg::DATA_W-1:0] data_lines_in,
  output logic ready_n,
  output logic next_address_request_n
);
  import nbc_pkg::*;
  logic [DATA_W-1:0] mem [0:15]; // small store, low word bits only
  logic active; // a cycle is being answered
  int cnt; // falling edges since the strobe
  // ready lands two clocks before it is sampled
  always @(negedge clk or posedge rst) begin
    int k, w;
    logic go, ack;
    if (rst) begin
      active <= 1'b0;
      cnt <= 0;
      ready_n <= 1'b1;
      next_address_request_n <= 1'b1;
      data_lines_in <= 16'h0000;
    end else begin
      w = int'(wait_states);
      k = active ? cnt + 1 : 0;
      go = active || (address_strobe_n === 1'b0);
      ack = go && (k == 2 * w || k == 2 * w + 1);
      ready_n <= !ack;
      // unanswered reads show flipped data
      if (ack && write_read_sel === 1'b0) begin
        data_lines_in <= mem[word_address_lines[3:0]];
      end else begin
        data_lines_in <= ~data_lines_in;
      end
      // next address only when asked, in waits
      next_address_request_n <= !(nx_in_wait && go && w > 0 && k >= 2);
      if (go && k == 2 * w + 1 && data_lines_oe_n === 1'b0) begin
        if (!low_byte_enable_n) mem[word_address_lines[3:0]][7:0] <= data_lines_out[7:0];
        if (!high_byte_enable_n) mem[word_address_lines[3:0]][15:8] <= data_lines_out[15:8];
      end
      active <= go && k < 2 * w + 1;
      cnt <= k;
    end
  end
endmodule

// ---- sim/tb_top.sv ----
/*
  bus sequencer bench: core requests, partner model, pin monitor.
  assumes package, design and partner compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import nbc_pkg::*;
  logic clk, sys_rst, req_valid, req_lock, req_ready, rsp_valid, address_strobe_n;
  logic high_byte_enable_n, low_byte_enable_n, mem_io_sel, data_ctrl_sel, write_read_sel;
  logic lock_n, cycle_def_oe_n, data_lines_oe_n, ready_n, next_address_request_n;
  logic hold_request, bus_grant_acknowledge, pipeline_handoff, nx_in_wait;
  nbc_kind_t req_kind;
  nbc_size_t req_size;
  logic [ADDR_W-1:0] req_addr;
  logic [OPER_W-1:0] req_wdata, rsp_rdata;
  logic [WADDR_W-1:0] word_address_lines, cap_addr;
  logic [DATA_W-1:0] data_lines_in, data_lines_out;
  logic [3:0] wait_states;
  logic [1:0] cap_en; // last strobe: {high, low} enables
  logic [2:0] cap_def; // last strobe: definition code
  logic cap_lock, cap_ok;
  int n_fail = 0, n_compared = 0, n_strobe = 0, n_handoff = 0, st_len = 0, cyc = 0;

  nbc_bus_seq i_nbc_bus_seq (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_kind(req_kind), .req_size(req_size), .req_lock(req_lock), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .address_strobe_n(address_strobe_n),
    .word_address_lines(word_address_lines), .high_byte_enable_n(high_byte_enable_n),
    .low_byte_enable_n(low_byte_enable_n), .mem_io_sel(mem_io_sel),
    .data_ctrl_sel(data_ctrl_sel), .write_read_sel(write_read_sel), .lock_n(lock_n),
    .cycle_def_oe_n(cycle_def_oe_n), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n), .ready_n(ready_n),
    .next_address_request_n(next_address_request_n), .hold_request(hold_request),
    .bus_grant_acknowledge(bus_grant_acknowledge), .pipeline_handoff(pipeline_handoff));
  nbc_partner i_nbc_partner (.clk(clk), .rst(sys_rst), .address_strobe_n(address_strobe_n),
    .word_address_lines(word_address_lines), .high_byte_enable_n(high_byte_enable_n),
    .low_byte_enable_n(low_byte_enable_n), .write_read_sel(write_read_sel),
    .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n),
    .wait_states(wait_states), .nx_in_wait(nx_in_wait), .data_lines_in(data_lines_in),
    .ready_n(ready_n), .next_address_request_n(next_address_request_n));

  // 40 MHz double-rate clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard, well above run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // lock, definition, enables, word address
  function automatic logic [31:0] tup(logic l, logic [2:0] d, logic [1:0] e, logic [22:0] a);
    return {l, d, e, 3'h0, a};
  endfunction

  function automatic logic [2:0] def_of(nbc_kind_t k);
    case (k)
      NBC_MEM_RD: return DEF_MEM_RD;
      NBC_MEM_WR: return DEF_MEM_WR;
      NBC_IO_RD: return DEF_IO_RD;
      NBC_IO_WR: return DEF_IO_WR;
      NBC_CODE_RD: return DEF_CODE_RD;
      NBC_HALT, NBC_SHUTDOWN: return DEF_HALT;
      default: return DEF_INTA;
    endcase
  endfunction

  // pin monitor: strobe capture, length, held pins
  always @(negedge clk) begin
    if (sys_rst) begin
      cap_ok = 1'b0;
      st_len = 0;
    end else if (address_strobe_n === 1'b0) begin
      if (st_len == 0) begin
        n_strobe++;
        cap_addr = word_address_lines;
        cap_en = {high_byte_enable_n, low_byte_enable_n};
        cap_def = {mem_io_sel, data_ctrl_sel, write_read_sel};
        cap_lock = lock_n;
        cap_ok = 1'b1;
      end
      if (cap_def == DEF_MEM_WR || cap_def == DEF_IO_WR) begin
        chk("write drive", 32'(st_len == 0), 32'(data_lines_oe_n));
      end
      st_len++;
    end else begin
      if (st_len != 0) chk("strobe length", 2, st_len);
      st_len = 0;
      // floated pins are not compared
      if (cycle_def_oe_n !== 1'b0) cap_ok = 1'b0;
      if (cap_ok) chk("held cycle", tup(cap_lock, cap_def, cap_en, cap_addr), tup(lock_n,
        {mem_io_sel, data_ctrl_sel, write_read_sel}, {high_byte_enable_n, low_byte_enable_n},
        word_address_lines));
    end
    if (pipeline_handoff === 1'b1) n_handoff++;
  end

  // one operand: hold until taken, return when done
  task automatic do_req(nbc_kind_t k, nbc_size_t s, logic lk, logic [23:0] a,
    logic [31:0] wd, output int lat);
    int n;
    @(negedge clk);
    req_kind = k;
    req_size = s;
    req_lock = lk;
    req_addr = a;
    req_wdata = wd;
    req_valid = 1'b1;
    #12;
    n = 0;
    // combinational ready: look just before the edge
    while (req_ready !== 1'b1 && n < 60) begin
      @(negedge clk);
      #12;
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    lat = 1;
    while (rsp_valid !== 1'b1 && lat < 200) begin
      @(negedge clk);
      lat++;
    end
    chk("request taken", 1, 32'(n < 60));
  endtask

  task automatic t_rst_pins();
    chk("reset pins", 32'h0000001A, 32'({address_strobe_n, data_lines_oe_n,
      bus_grant_acknowledge, lock_n, rsp_valid}));
  endtask

  task automatic t_read16();
    int lat, s0;
    i_nbc_partner.mem[4] = 16'hA55A;
    s0 = n_strobe;
    do_req(NBC_MEM_RD, NBC_SZ16, 1'b0, 24'h000008, 32'h00000000, lat);
    chk("read latency", 5, lat);
    chk("read data", 32'h0000A55A, {16'h0000, rsp_rdata[15:0]});
    chk("read pins", tup(1'b1, DEF_MEM_RD, 2'h0, 23'h000004),
      tup(cap_lock, cap_def, cap_en, cap_addr));
    chk("read strobes", 1, n_strobe - s0);
    repeat (6) @(negedge clk);
    chk("idle strobes", 1, n_strobe - s0);
  endtask

  task automatic t_write_wait();
    int lat;
    i_nbc_partner.mem[6] = 16'h0000;
    wait_states = 4'h3;
    do_req(NBC_MEM_WR, NBC_SZ16, 1'b1, 24'h00000C, 32'h0000BEEF, lat);
    chk("write latency", 11, lat);
    chk("write pins", tup(1'b0, DEF_MEM_WR, 2'h0, 23'h000006),
      tup(cap_lock, cap_def, cap_en, cap_addr));
    chk("write hold data", 32'h0000BEEF, {16'h0000, data_lines_out});
    chk("write hold drive", 0, 32'(data_lines_oe_n));
    @(negedge clk);
    chk("write release", 1, 32'(data_lines_oe_n));
    chk("stored word", 32'h0000BEEF, {16'h0000, i_nbc_partner.mem[6]});
    wait_states = 4'h0;
  endtask

  task automatic t_split();
    int lat, s0;
    i_nbc_partner.mem[8] = 16'hB100;
    i_nbc_partner.mem[9] = 16'hB3B2;
    i_nbc_partner.mem[10] = 16'h00B4;
    s0 = n_strobe;
    do_req(NBC_MEM_RD, NBC_SZ32, 1'b0, 24'h000011, 32'h00000000, lat);
    chk("split data", 32'hB4B3B2B1, rsp_rdata);
    chk("split cycles", 3, n_strobe - s0);
    chk("last piece", tup(1'b1, DEF_MEM_RD, 2'h2, 23'h00000A),
      tup(cap_lock, cap_def, cap_en, cap_addr));
  endtask

  task automatic t_kinds();
    int lat;
    nbc_kind_t kd;
    logic sp;
    logic [22:0] wa;
    for (int k = 0; k < 8; k++) begin
      kd = nbc_kind_t'(k);
      sp = (kd == NBC_HALT || kd == NBC_SHUTDOWN);
      wa = (kd == NBC_HALT) ? HALT_WADDR : (kd == NBC_SHUTDOWN) ? SHUT_WADDR : 23'h000002;
      do_req(kd, NBC_SZ16, 1'b0, 24'h000004, 32'h00001234, lat);
      chk("kind pins", tup(kd != NBC_INTA, def_of(kd), (sp || kd == NBC_INTA) ? 2'h2 : 2'h0, wa),
        tup(cap_lock, cap_def, cap_en, cap_addr));
    end
  endtask

  task automatic t_hold();
    int lat, n, s0;
    hold_request = 1'b1;
    n = 0;
    while (bus_grant_acknowledge !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("grant", 1, 32'(bus_grant_acknowledge));
    chk("definition float", 1, 32'(cycle_def_oe_n));
    req_kind = NBC_MEM_RD;
    req_size = NBC_SZ16;
    req_addr = 24'h000008;
    req_valid = 1'b1;
    s0 = n_strobe;
    n = 0;
    // a request in hold must wait
    repeat (8) begin
      #12;
      if (req_ready === 1'b1) n++;
      @(negedge clk);
    end
    chk("taken in hold", 0, n);
    req_valid = 1'b0;
    hold_request = 1'b0;
    n = 0;
    while (bus_grant_acknowledge !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("grant drop", 0, 32'(bus_grant_acknowledge));
    chk("strobe in hold", 0, n_strobe - s0);
    do_req(NBC_MEM_RD, NBC_SZ16, 1'b0, 24'h000008, 32'h00000000, lat);
    chk("after hold latency", 5, lat);
  endtask

  task automatic t_nxt();
    int lat, h0;
    wait_states = 4'h2;
    nx_in_wait = 1'b1;
    h0 = n_handoff;
    do_req(NBC_MEM_RD, NBC_SZ16, 1'b0, 24'h000008, 32'h00000000, lat);
    chk("nx latency", 9, lat);
    chk("nx data", 32'h0000A55A, {16'h0000, rsp_rdata[15:0]});
    repeat (2) @(negedge clk);
    chk("handoff", 1, 32'(n_handoff > h0));
    nx_in_wait = 1'b0;
    wait_states = 4'h0;
  endtask

  task automatic t_reset_mid();
    int lat, n, s0;
    wait_states = 4'h5;
    i_nbc_partner.mem[3] = 16'h5A5A;
    req_kind = NBC_MEM_WR;
    req_addr = 24'h000006;
    req_wdata = 32'h0000FFFF;
    req_valid = 1'b1;
    n = 0;
    while (address_strobe_n !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    req_valid = 1'b0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    t_rst_pins();
    sys_rst = 1'b0;
    s0 = n_strobe;
    n = 0;
    repeat (12) begin
      @(negedge clk);
      if (rsp_valid === 1'b1) n++;
    end
    chk("aborted answer", 0, n + n_strobe - s0);
    chk("aborted write", 32'h00005A5A, {16'h0000, i_nbc_partner.mem[3]});
    wait_states = 4'h0;
    do_req(NBC_MEM_RD, NBC_SZ16, 1'b0, 24'h000006, 32'h00000000, lat);
    chk("after reset", 32'h00055A5A, {11'h000, 5'(lat), rsp_rdata[15:0]});
  endtask

  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_kind = NBC_MEM_RD;
    req_size = NBC_SZ16;
    req_lock = 1'b0;
    req_addr = 24'h000000;
    req_wdata = 32'h00000000;
    hold_request = 1'b0;
    nx_in_wait = 1'b0;
    wait_states = 4'h0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    t_rst_pins();
    sys_rst = 1'b0;
    t_read16();
    t_write_wait();
    t_split();
    t_kinds();
    t_hold();
    t_nxt();
    t_reset_mid();
    final_report();
  end
endmodule
